/* File: logic/pin_mux_pkg.sv */
// package: register map, field layout and encodings of the port c/d pin mux
package pin_mux_pkg;

   // ************************************************************
   // register byte addresses (word aligned)
   // ************************************************************
   localparam logic [5:0] ADDR_PC_LOW_SEL = 6'h00;
   localparam logic [5:0] ADDR_PC_HIGH_SEL = 6'h04;
   localparam logic [5:0] ADDR_PD_SEL = 6'h08;
   localparam logic [5:0] ADDR_IN_SRC = 6'h0c;
   localparam logic [5:0] ADDR_PORT_A = 6'h10;
   localparam logic [5:0] ADDR_PORT_C = 6'h14;
   localparam logic [5:0] ADDR_PORT_D = 6'h18;
   localparam logic [5:0] ADDR_WAKE = 6'h1c;
   localparam logic [5:0] ADDR_BITOP = 6'h20;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [7:0] PORT_RESET = 8'hff;
   localparam logic [7:0] WAKE_RESET = 8'h00;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int PC3_LSB = 6;
   localparam int PC2_LSB = 4;
   localparam int PC1_LSB = 2;
   localparam int PC0_LSB = 0;
   localparam int PC4_LSB = 0;
   localparam int PD3_LSB = 6;
   localparam int PD1_LSB = 2;
   localparam int IRQ2_SRC_BIT = 5;
   localparam int IRQ1_SRC_BIT = 4;
   localparam int SDI_SRC_BIT = 3;
   localparam int SCK_SRC_BIT = 2;
   localparam int KEEP_SRC_BIT = 1;
   localparam int RX_SRC_BIT = 0;
   localparam logic [7:0] PC_HIGH_IMPL_MASK = 8'h3f;
   localparam logic [7:0] IN_SRC_IMPL_MASK = 8'h3f;

   // bit operation register: [9] set(1)/clear(0), [8] port d, [2:0] bit
   localparam int BITOP_SET_BIT = 9;
   localparam int BITOP_PORTD_BIT = 8;

   // ************************************************************
   // pin function codes
   // ************************************************************
   typedef enum logic [2:0] {
      FN_GPIO,
      FN_SERIAL_OUT,
      FN_SERIAL_IN,
      FN_UART,
      FN_LCD,
      FN_OSC,
      FN_ANALOG
   } pin_fn_t;

   // port c pins 0..4, port d pins 0..3 routing
   typedef struct packed {
      pin_fn_t [4:0] port_c;
      pin_fn_t [3:0] port_d;
   } pin_route_t;

   // peripheral input source steering, resolved to pin levels
   typedef struct packed {
      logic irq1_in;
      logic irq2_in;
      logic sdi_in;
      logic sck_in;
      logic rx_in;
   } periph_in_t;

endpackage

/* File: logic/pin_mux.sv */
// pin function multiplexer for ports c and d with source steering
`timescale 1ns/1ns
module pin_mux
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [5:2] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic sleep_i,
   input wire logic [7:0] port_a_pin_i,
   input wire logic [7:0] port_b_pin_i,
   input wire logic [4:0] port_c_pin_i,
   output logic [4:0] port_c_out_o,
   output logic [4:0] port_c_oe_o,
   output logic [3:0] port_d_oe_o,
   output logic [3:0] port_d_out_o,
   output pin_mux_pkg::pin_route_t route_o,
   output pin_mux_pkg::periph_in_t periph_in_o,
   output logic wake_o
);
   import pin_mux_pkg::*;

   // ************************************************************
   // decode helpers
   // ************************************************************
   function automatic pin_fn_t pc_serial_out_fn(input logic [1:0] f);
      return (f == 2'b10) ? FN_SERIAL_OUT : (f == 2'b11) ? FN_LCD : FN_GPIO;
   endfunction

   function automatic pin_fn_t pc_uart_fn(input logic [1:0] f);
      return (f == 2'b01) ? FN_UART : (f == 2'b10) ? FN_LCD :
         (f == 2'b11) ? FN_OSC : FN_GPIO;
   endfunction

   // reserved codes 01/10 fall back to gpio
   function automatic pin_fn_t pd_fn(input logic [1:0] f);
      return (f == 2'b11) ? FN_ANALOG : FN_GPIO;
   endfunction

   // ************************************************************
   // bus and registers
   // ************************************************************
   logic [7:0] pc_low_sel_reg, pc_high_sel_reg, pd_sel_reg, in_src_reg;
   logic [7:0] pa_data_reg, pa_dir_reg, wake_en_reg;
   logic [4:0] pc_data_reg, pc_dir_reg;
   logic [3:0] pd_data_reg, pd_dir_reg;
   logic [31:0] rd_next;
   logic [5:0] adr;
   logic hit, wr, req;
   logic [7:0] bop_byte, bop_new;
   logic [7:0] pa_s1, pa_s2, pa_s3, pa_clean;
   logic [7:0] pb_s1, pb_s2, pb_s3, pb_clean;
   logic [4:0] pc_s1, pc_s2, pc_s3, pc_clean;

   assign adr = {wb_adr_i, 2'b00};
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   // byte lanes are checked per register, so a direction-only write works
   assign wr = req && wb_we_i && hit;

   always_comb begin
      hit = 1'b1;
      rd_next = 32'h0000_0000;
      if (adr == 6'(ADDR_PC_LOW_SEL)) begin
         rd_next[7:0] = pc_low_sel_reg;
      end else if (adr == 6'(ADDR_PC_HIGH_SEL)) begin
         rd_next[7:0] = pc_high_sel_reg & PC_HIGH_IMPL_MASK;
      end else if (adr == 6'(ADDR_PD_SEL)) begin
         rd_next[7:0] = pd_sel_reg;
      end else if (adr == 6'(ADDR_IN_SRC)) begin
         rd_next[7:0] = in_src_reg & IN_SRC_IMPL_MASK;
      end else if (adr == 6'(ADDR_PORT_A)) begin
         rd_next[23:0] = {pa_clean, pa_dir_reg, pa_data_reg};
      end else if (adr == 6'(ADDR_PORT_C)) begin
         rd_next[20:0] = {pc_clean, 3'h0, pc_dir_reg, 3'h0, pc_data_reg};
      end else if (adr == 6'(ADDR_PORT_D)) begin
         rd_next[11:0] = {pd_dir_reg, 4'h0, pd_data_reg};
      end else if (adr == 6'(ADDR_WAKE)) begin
         rd_next[7:0] = wake_en_reg;
      end else if (adr == 6'(ADDR_BITOP)) begin
         rd_next = 32'h0000_0000;
      end else begin
         hit = 1'b0;
      end
   end

   // single wait-free answer: ack or err one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req && hit;
         wb_err_o <= req && !hit;
         wb_dat_o <= req ? rd_next : 32'h0000_0000;
      end
   end

   // ************************************************************
   // select registers
   // ************************************************************
   // clear at reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_low_sel_reg <= SEL_RESET;
         pc_high_sel_reg <= SEL_RESET;
         pd_sel_reg <= SEL_RESET;
         in_src_reg <= SEL_RESET;
      end else if (wr && wb_sel_i[0]) begin
         if (adr == 6'(ADDR_PC_LOW_SEL)) begin
            pc_low_sel_reg <= wb_dat_i[7:0];
         end else if (adr == 6'(ADDR_PC_HIGH_SEL)) begin
            pc_high_sel_reg <= wb_dat_i[7:0] & PC_HIGH_IMPL_MASK;
         end else if (adr == 6'(ADDR_PD_SEL)) begin
            pd_sel_reg <= wb_dat_i[7:0];
         end else if (adr == 6'(ADDR_IN_SRC)) begin
            in_src_reg <= wb_dat_i[7:0] & IN_SRC_IMPL_MASK;
         end
      end
   end

   // ************************************************************
   // port data and direction, bit set/clear
   // ************************************************************
   // the bit operation reads the stored direction byte, so unchanged bits keep
   // their stored value even if the pin level differs
   assign bop_byte = wb_dat_i[BITOP_PORTD_BIT] ? {4'h0, pd_dir_reg} :
      {3'h0, pc_dir_reg};
   always_comb begin
      bop_new = bop_byte;
      bop_new[wb_dat_i[2:0]] = wb_dat_i[BITOP_SET_BIT];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pa_data_reg <= PORT_RESET;
         pa_dir_reg <= PORT_RESET;
         pc_data_reg <= PORT_RESET[4:0];
         pc_dir_reg <= PORT_RESET[4:0];
         pd_data_reg <= PORT_RESET[3:0];
         pd_dir_reg <= PORT_RESET[3:0];
      end else if (wr) begin
         if (adr == 6'(ADDR_PORT_A)) begin
            pa_data_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : pa_data_reg;
            if (wb_sel_i[1]) begin
               pa_dir_reg <= wb_dat_i[15:8];
            end
         end else if (adr == 6'(ADDR_PORT_C)) begin
            pc_data_reg <= wb_sel_i[0] ? wb_dat_i[4:0] : pc_data_reg;
            if (wb_sel_i[1]) begin
               pc_dir_reg <= wb_dat_i[12:8];
            end
         end else if (adr == 6'(ADDR_PORT_D)) begin
            pd_data_reg <= wb_sel_i[0] ? wb_dat_i[3:0] : pd_data_reg;
            if (wb_sel_i[1]) begin
               pd_dir_reg <= wb_dat_i[11:8];
            end
         end else if (adr == 6'(ADDR_BITOP) && wb_sel_i[0]) begin
            if (wb_dat_i[BITOP_PORTD_BIT]) begin
               pd_dir_reg <= bop_new[3:0];
            end else begin
               pc_dir_reg <= bop_new[4:0];
            end
         end
      end
   end

   // ************************************************************
   // routing
   // ************************************************************
   pin_route_t route_next;
   always_comb begin
      route_next.port_c[3] = pc_serial_out_fn(pc_low_sel_reg[PC3_LSB+:2]);
      route_next.port_c[2] = pc_serial_out_fn(pc_low_sel_reg[PC2_LSB+:2]);
      route_next.port_c[1] = pc_uart_fn(pc_low_sel_reg[PC1_LSB+:2]);
      route_next.port_c[0] = pc_uart_fn(pc_low_sel_reg[PC0_LSB+:2]);
      if (pc_high_sel_reg[PC4_LSB+:2] == 2'b10) begin
         route_next.port_c[4] = FN_SERIAL_IN;
      end else if (pc_high_sel_reg[PC4_LSB+:2] == 2'b11) begin
         route_next.port_c[4] = FN_LCD;
      end else begin
         route_next.port_c[4] = FN_GPIO;
      end
      route_next.port_d[3] = pd_fn(pd_sel_reg[PD3_LSB+:2]);
      route_next.port_d[1] = pd_fn(pd_sel_reg[PD1_LSB+:2]);
      route_next.port_d[2] = FN_GPIO;
      route_next.port_d[0] = FN_GPIO;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         route_o <= '0;
         {port_c_oe_o, port_c_out_o, port_d_oe_o, port_d_out_o} <= 18'h0;
      end else begin
         route_o <= route_next;
         for (int i = 0; i < 5; i++) begin
            port_c_oe_o[i] <= !pc_dir_reg[i] &&
               (route_next.port_c[i] == FN_GPIO);
            port_c_out_o[i] <= pc_data_reg[i];
         end
         for (int i = 0; i < 4; i++) begin
            port_d_oe_o[i] <= !pd_dir_reg[i] &&
               (route_next.port_d[i] == FN_GPIO);
            port_d_out_o[i] <= pd_data_reg[i];
         end
      end
   end

   // ************************************************************
   // input synchronisers and steering
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {pa_s1, pa_s2, pa_s3, pa_clean} <= '1;
         {pb_s1, pb_s2, pb_s3, pb_clean} <= '1;
         {pc_s1, pc_s2, pc_s3, pc_clean} <= '1;
      end else begin
         pa_s1 <= port_a_pin_i;
         pa_s2 <= pa_s1;
         pa_s3 <= pa_s2;
         pb_s1 <= port_b_pin_i;
         pb_s2 <= pb_s1;
         pb_s3 <= pb_s2;
         pc_s1 <= port_c_pin_i;
         pc_s2 <= pc_s1;
         pc_s3 <= pc_s2;
         // a change counts once stages two and three agree
         for (int i = 0; i < 8; i++) begin
            if (pa_s2[i] == pa_s3[i]) begin
               pa_clean[i] <= pa_s3[i];
            end
            if (pb_s2[i] == pb_s3[i]) begin
               pb_clean[i] <= pb_s3[i];
            end
         end
         for (int i = 0; i < 5; i++) begin
            if (pc_s2[i] == pc_s3[i]) begin
               pc_clean[i] <= pc_s3[i];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_in_o <= '1;
      end else begin
         periph_in_o.irq2_in <= in_src_reg[IRQ2_SRC_BIT] ? pa_clean[2] :
            pb_clean[1];
         periph_in_o.irq1_in <= in_src_reg[IRQ1_SRC_BIT] ? pa_clean[1] :
            pb_clean[0];
         periph_in_o.sdi_in <= in_src_reg[SDI_SRC_BIT] ? pa_clean[3] :
            pc_clean[4];
         periph_in_o.sck_in <= in_src_reg[SCK_SRC_BIT] ? pb_clean[6] : 1'b1;
         periph_in_o.rx_in <= in_src_reg[RX_SRC_BIT] ? pc_clean[1] : 1'b1;
      end
   end

   // ************************************************************
   // port a wake-up
   // ************************************************************
   logic [7:0] pa_prev;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_en_reg <= WAKE_RESET;
      end else if (wr && wb_sel_i[0] && adr == 6'(ADDR_WAKE)) begin
         wake_en_reg <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pa_prev <= 8'hff;
         wake_o <= 1'b0;
      end else begin
         pa_prev <= pa_clean;
         wake_o <= sleep_i && |(pa_prev & ~pa_clean & wake_en_reg);
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_pc_high_top_zero;
      @(posedge clk_i) disable iff (rst_i)
      (wb_ack_o && $past(adr) == 6'(ADDR_PC_HIGH_SEL) && !$past(wb_we_i))
         |-> wb_dat_o[7:6] == 2'b00;
   endproperty
   a_pc_high_top_zero: assert property (p_pc_high_top_zero)
      else $error("pc high select top bits not zero");

   property p_pc3_route;
      @(posedge clk_i) disable iff (rst_i)
      pc_low_sel_reg[7:6] == 2'b11 |=> route_o.port_c[3] == FN_LCD;
   endproperty
   a_pc3_route: assert property (p_pc3_route)
      else $error("pc3 lcd routing missing");

   property p_pc1_osc;
      @(posedge clk_i) disable iff (rst_i)
      pc_low_sel_reg[3:2] == 2'b11 |=> route_o.port_c[1] == FN_OSC;
   endproperty
   a_pc1_osc: assert property (p_pc1_osc)
      else $error("pc1 oscillator routing missing");

   property p_pc0_uart;
      @(posedge clk_i) disable iff (rst_i)
      pc_low_sel_reg[1:0] == 2'b01 |=> route_o.port_c[0] == FN_UART;
   endproperty
   a_pc0_uart: assert property (p_pc0_uart)
      else $error("pc0 uart routing missing");

   property p_pd3_analog;
      @(posedge clk_i) disable iff (rst_i)
      pd_sel_reg[7:6] != 2'b11 |=> route_o.port_d[3] == FN_GPIO;
   endproperty
   a_pd3_analog: assert property (p_pd3_analog)
      else $error("pd3 analog selected without code 11");

   property p_irq2_steer;
      @(posedge clk_i) disable iff (rst_i)
      in_src_reg[5] |=> periph_in_o.irq2_in == $past(pa_clean[2]);
   endproperty
   a_irq2_steer: assert property (p_irq2_steer)
      else $error("second irq not taken from pa2");

   property p_sdi_steer;
      @(posedge clk_i) disable iff (rst_i)
      !in_src_reg[3] |=> periph_in_o.sdi_in == $past(pc_clean[4]);
   endproperty
   a_sdi_steer: assert property (p_sdi_steer)
      else $error("serial data not taken from pc4");

   property p_reset_inputs;
      @(posedge clk_i) $fell(rst_i) |-> pc_dir_reg == 5'h1f &&
         pd_dir_reg == 4'hf && pa_dir_reg == 8'hff;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs)
      else $error("ports not inputs after reset");

   property p_wake_needs_enable;
      @(posedge clk_i) disable iff (rst_i)
      ##1 wake_o |-> $past(sleep_i) && $past(wake_en_reg) != 8'h00;
   endproperty
   a_wake_needs_enable: assert property (p_wake_needs_enable)
      else $error("wake without sleep or enable");

endmodule

/* File: tb/pin_far_side.sv */
// far side model: package pins of port c as seen by the pin mux
`timescale 1ns/1ns
module pin_far_side (
   input wire logic [4:0] port_c_out_i,
   input wire logic [4:0] port_c_oe_i,
   input wire logic [4:0] pc_ext_i,
   output logic [4:0] port_c_pin_o
);
   // a driven pin reads back its own level, an input pin the outside level
   assign port_c_pin_o = (port_c_oe_i & port_c_out_i) |
      (~port_c_oe_i & pc_ext_i);
endmodule

/* File: tb/pin_mux_test.sv */
// self-checking bench for the port c/d pin function mux
`timescale 1ns/1ns
module pin_mux_test;
   import pin_mux_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:2] wb_adr_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_ack_o;
   logic wb_err_o;
   logic sleep_i = 1'b0;
   logic [7:0] pa_ext = 8'hff;
   logic [7:0] pb_ext = 8'hff;
   logic [4:0] pc_ext = 5'h1f;
   logic [4:0] port_c_pin;
   logic [4:0] port_c_out_o;
   logic [4:0] port_c_oe_o;
   logic [3:0] port_d_oe_o;
   logic [3:0] port_d_out_o;
   pin_route_t route_o;
   periph_in_t periph_in_o;
   logic wake_o;
   int mismatches = 0;
   int compares = 0;
   integer seed = 32'hcd8c32f7;
   logic [31:0] rd;
   logic er;
   logic [7:0] v;
   logic [4:0] d5;
   logic [2:0] k;
   int n;

   always #25 clk_i = ~clk_i;

   pin_mux u_pin_mux (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_i(sleep_i),
      .port_a_pin_i(pa_ext), .port_b_pin_i(pb_ext),
      .port_c_pin_i(port_c_pin), .port_c_out_o(port_c_out_o),
      .port_c_oe_o(port_c_oe_o), .port_d_oe_o(port_d_oe_o),
      .port_d_out_o(port_d_out_o), .route_o(route_o),
      .periph_in_o(periph_in_o), .wake_o(wake_o));

   pin_far_side u_pin_far_side (.port_c_out_i(port_c_out_o),
      .port_c_oe_i(port_c_oe_o), .pc_ext_i(pc_ext),
      .port_c_pin_o(port_c_pin));

   // ************************************************************
   // checking and bus tasks
   // ************************************************************
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // classic single cycle; waits for ack or err, only the watchdog ends a hang
   task automatic bus(input logic [7:0] a, input logic w,
         input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a[5:2];
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   // counts wake pulses after pulling port a to lvl from all high
   task automatic count_wake(input logic [7:0] lvl);
      pa_ext <= 8'hff;
      repeat (8) @(posedge clk_i);
      pa_ext <= lvl;
      n = 0;
      repeat (12) begin
         @(posedge clk_i);
         if (wake_o === 1'b1) n++;
      end
   endtask

   // ************************************************************
   // expectations
   // ************************************************************
   function automatic pin_fn_t fn_pc(input int pin, input logic [1:0] c);
      if (pin <= 1) return (c == 2'b01) ? FN_UART : (c == 2'b10) ? FN_LCD :
         (c == 2'b11) ? FN_OSC : FN_GPIO;
      if (c == 2'b11) return FN_LCD;
      if (c == 2'b10) return (pin == 4) ? FN_SERIAL_IN : FN_SERIAL_OUT;
      return FN_GPIO;
   endfunction

   function automatic pin_fn_t fn_pd(input logic [1:0] c);
      return (c == 2'b11) ? FN_ANALOG : FN_GPIO;
   endfunction

   // reserved steering codes leave the peripheral input idle high
   function automatic logic [4:0] exp_src(input logic [7:0] s,
         input logic [7:0] a, input logic [7:0] b, input logic [4:0] c);
      return {s[4] ? a[1] : b[0], s[5] ? a[2] : b[1], s[3] ? a[3] : c[4],
         s[2] ? b[6] : 1'b1, s[0] ? c[1] : 1'b1};
   endfunction

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #(50 * 20000);
      mismatches++;
      summarize();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 16; a += 4) begin
         bus(8'(a), 1'b0, 32'h0, 4'hf);
         chk("select reset", 32'h0, {24'h0, rd[7:0]});
      end
      bus(8'h14, 1'b0, 32'h0, 4'hf);
      chk("port c reset", 32'h1f1f,
         {rd[15:8] & 8'h1f, rd[7:0] & 8'h1f});
      bus(8'h18, 1'b0, 32'h0, 4'hf);
      chk("port d reset", 32'hff, {rd[11:8], rd[3:0]});
      chk("oe reset", 32'h0, {port_c_oe_o, port_d_oe_o});
      chk("route reset", 32'h0, {5'h0, route_o});
      $display("test reset done");

      for (int c = 0; c < 4; c++) begin
         v = {4{2'(c)}};
         bus(8'h00, 1'b1, {24'h0, v}, 4'hf);
         bus(8'h04, 1'b1, {30'h0, v[1:0]}, 4'hf);
         bus(8'h08, 1'b1, {24'h0, v & 8'hcc}, 4'hf);
         @(posedge clk_i);
         for (int p = 0; p < 5; p++)
            chk("pc route", fn_pc(p, v[1:0]),
               route_o.port_c[p]);
         chk("pd3 route", fn_pd(v[1:0]), route_o.port_d[3]);
         chk("pd1 route", fn_pd(v[1:0]), route_o.port_d[1]);
         bus(8'h00, 1'b0, 32'h0, 4'hf);
         chk("pc low read", {24'h0, v}, {24'h0, rd[7:0]});
      end
      bus(8'h04, 1'b1, 32'hc3, 4'hf);
      bus(8'h04, 1'b0, 32'h0, 4'hf);
      chk("pc high read", 32'h03, {24'h0, rd[7:0]});
      bus(8'h24, 1'b0, 32'h0, 4'hf);
      chk("unmapped err", 32'h1, {31'h0, er});
      $display("test select done");

      for (int i = 0; i < 10; i++) begin
         v = 8'($random(seed));
         if (i == 0) v[2:0] = 3'b000;
         if (i == 1) v[5:2] = 4'hf;
         v[1] = 1'b0;
         bus(8'h0c, 1'b1, {24'h0, v}, 4'hf);
         bus(8'h0c, 1'b0, 32'h0, 4'hf);
         chk("steer read", {26'h0, v[5:0]}, {24'h0, rd[7:0]});
         pa_ext <= 8'($random(seed));
         pb_ext <= 8'($random(seed));
         pc_ext <= 5'($random(seed));
         repeat (8) @(posedge clk_i);
         chk("steer", exp_src(v, pa_ext, pb_ext, pc_ext),
            periph_in_o);
      end
      $display("test steering done");

      bus(8'h00, 1'b1, 32'h0, 4'hf);
      bus(8'h04, 1'b1, 32'h0, 4'hf);
      bus(8'h08, 1'b1, 32'h0, 4'hf);
      bus(8'h14, 1'b1, 32'h0, 4'h2);
      @(posedge clk_i);
      chk("new output level", 32'h3ff, {port_c_oe_o, port_c_out_o});
      d5 = 5'($random(seed));
      bus(8'h14, 1'b1, {27'h0, d5}, 4'h1);
      // pin levels read back only after the synchroniser settles
      repeat (4) @(posedge clk_i);
      bus(8'h14, 1'b0, 32'h0, 4'hf);
      chk("pc pins", {27'h0, d5}, {27'h0, rd[20:16]});
      bus(8'h20, 1'b1, 32'h202, 4'hf);
      bus(8'h14, 1'b0, 32'h0, 4'hf);
      chk("bit set", {22'h0, 5'h04, d5}, {22'h0, rd[12:8], rd[4:0]});
      chk("bit set oe", 32'h1b, {27'h0, port_c_oe_o});
      bus(8'h20, 1'b1, 32'h101, 4'hf);
      bus(8'h18, 1'b0, 32'h0, 4'hf);
      chk("bit clr", 32'hdf, {rd[11:8], rd[3:0]});
      chk("bit clr pins", 32'h2f, {port_d_oe_o, port_d_out_o});
      $display("test port done");

      k = 3'($random(seed));
      bus(8'h1c, 1'b1, {24'h0, 8'h1 << k}, 4'hf);
      sleep_i <= 1'b1;
      count_wake(~(8'h1 << k));
      chk("wake enabled", 32'h1, n);
      count_wake(~(8'h1 << 3'(k + 3'd1)));
      chk("wake masked", 32'h0, n);
      sleep_i <= 1'b0;
      count_wake(~(8'h1 << k));
      chk("wake awake", 32'h0, n);
      $display("test wake done");
      summarize();
   end
endmodule
